// [src/srb_pkg.sv]
// constants and carrier types for the receive buffer close status block
// assumes one system clock; no other package is needed
package srb_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          TMR_W         = 16;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS_A  = 8'h08;
  localparam logic [7:0]  OFS_FIFO      = 8'h0C;
  localparam logic [7:0]  OFS_MATCH     = 8'h10;
  localparam logic [7:0]  OFS_BUFFER_TIMEOUT_FLAG      = 8'h14;
  localparam logic [7:0]  OFS_CHAR_TIMEOUT_FLAG      = 8'h18;
  localparam int          POS_HIT       = 28;
  localparam int          POS_BUFFER_TIMEOUT_FLAG      = 27;
  localparam int          POS_CHAR_TIMEOUT_FLAG      = 26;
  localparam int          POS_RSVD      = 22;
  localparam int          POS_COUNT     = 20;
  localparam int          POS_MODEM     = 16;
  localparam int          POS_PENDING   = 11;
  localparam int          POS_CLOSED    = 9;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [2:0]  RST_COUNT     = 3'h0;
  localparam logic [2:0]  WORD_BYTES    = 3'h4;
  localparam logic [4:0]  RST_CTRL      = 5'h00;

  // control fields
  typedef struct packed {
    logic littleOrder;
    logic dmaMode;
    logic cgapEn;
    logic bgapEn;
    logic matchEn;
  } srb_ctrl_t;

  // descriptor status handed to the dma engine at buffer close
  typedef struct packed {
    logic        valid;
    logic [15:0] status;
  } srb_desc_t;
endpackage : srb_pkg

// [src/srb_status.sv]
// receive buffer close status: close reasons, word byte count, modem levels
// assumes rxValid/rxByte come from the receiver on ref_clk; modem pins are async
//
// What this block does
// - character match sets hit flag, closes buffer
// - matched character is last byte stored
// - dma mode copies hit flags to descriptor
// - hit flags meaningful only while buffer closed
// - buffer gap timeout from first byte closes
// - buffer timeout flag to descriptor in dma
// - character gap timeout from last byte closes
// - character timeout flag to descriptor in dma
// - two-bit valid byte count, 00 means four
// - byte order picks the byte lanes
// - bytes packed by selected byte order
// - carrier detect state follows its input
// - incoming call state follows ring input
// - modem-on state follows data set ready
// - send-permit state follows clear to send
// - writing one clears close-reason flags
// - close-reason flags updated at every close
// - word pending held off while buffer closed
`timescale 1ns/1ps
`default_nettype none
module srb_status
  import srb_pkg::*;
#(
  parameter int TIMER_W = TMR_W
)(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [31:0]       regRdData,
  input  wire logic              rxValid,
  input  wire logic [7:0]        rxByte,
  input  wire logic              carrierDetectPin,
  input  wire logic              ringPin,
  input  wire logic              dataSetReadyPin,
  input  wire logic              clearToSendPin,
  output srb_desc_t              descOut
);
  // timeout registers are loaded from one bus word
  if (TIMER_W < 1 || TIMER_W > 32)
  begin : g_bad_width
    $error("TIMER_W must be 1..32");
  end

  srb_ctrl_t          ctrl_reg, ctrl_next;
  logic [31:0]        match_reg, match_next;
  logic [TIMER_W-1:0] bgapVal_reg, bgapVal_next, cgapVal_reg, cgapVal_next;
  logic [TIMER_W-1:0] bufTmr_reg, bufTmr_next, chrTmr_reg, chrTmr_next;
  logic               bufOpen_reg, bufOpen_next;
  logic [5:0]         reason_reg, reason_next;
  logic               closed_reg, closed_next;
  logic [31:0]        asm_reg, asm_next, hold_reg, hold_next;
  logic [2:0]         asmCnt_reg, asmCnt_next, holdCnt_reg, holdCnt_next;
  logic               holdValid_reg, holdValid_next;
  logic               flushPend_reg, flushPend_next;
  logic [31:0]        rdData_reg, rdData_next;
  srb_desc_t          desc_reg, desc_next;
  logic [3:0]         sync1_reg, sync2_reg, sync3_reg;
  logic [3:0]         modem_reg, modem_next;
  logic [3:0]         hitVec;
  logic               byteTake, matchClose, bgapExp, cgapExp, closeNow;
  logic [5:0]         newReason;
  logic [31:0]        statusWord;
  logic [1:0]         lane;

  // compare each configured match character against the incoming byte
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_hit
      assign hitVec[3-gi] = (match_reg[gi*8 +: 8] == rxByte);
    end
  endgenerate

  assign statusWord = {reason_reg, 4'h0, holdCnt_reg[1:0], modem_reg,
                       4'h0, holdValid_reg & ~closed_reg, 1'b0, closed_reg,
                       9'h000};

  // new bytes are dropped, not held, while a closed buffer's tail is still being flushed
  assign byteTake   = rxValid && asmCnt_reg != WORD_BYTES && !flushPend_reg;
  assign matchClose = byteTake && ctrl_reg.matchEn && (hitVec != 4'h0);
  assign bgapExp    = ctrl_reg.bgapEn && bufOpen_reg && bgapVal_reg != '0
                      && bufTmr_reg == bgapVal_reg;
  assign cgapExp    = ctrl_reg.cgapEn && bufOpen_reg && !byteTake
                      && cgapVal_reg != '0 && chrTmr_reg == cgapVal_reg;
  assign closeNow   = matchClose || bgapExp || cgapExp;
  assign newReason  = {hitVec & {4{matchClose}}, bgapExp, cgapExp};

  always_comb
  begin
    ctrl_next      = ctrl_reg;
    match_next     = match_reg;
    bgapVal_next   = bgapVal_reg;
    cgapVal_next   = cgapVal_reg;
    bufTmr_next    = bufTmr_reg;
    chrTmr_next    = chrTmr_reg;
    bufOpen_next   = bufOpen_reg;
    reason_next    = reason_reg;
    closed_next    = closed_reg;
    asm_next       = asm_reg;
    asmCnt_next    = asmCnt_reg;
    hold_next      = hold_reg;
    holdCnt_next   = holdCnt_reg;
    holdValid_next = holdValid_reg;
    flushPend_next = flushPend_reg;
    rdData_next    = RST_WORD;
    desc_next      = '0;
    lane           = ctrl_reg.littleOrder ? asmCnt_reg[1:0] : 2'(3 - asmCnt_reg[1:0]);

    if (regWrStb)
    begin
      if (regAddr == OFS_CTRL)
        ctrl_next = srb_ctrl_t'(regWrData[4:0]);
      else if (regAddr == OFS_MATCH)
        match_next = regWrData;
      else if (regAddr == OFS_BUFFER_TIMEOUT_FLAG)
        bgapVal_next = regWrData[TIMER_W-1:0];
      else if (regAddr == OFS_CHAR_TIMEOUT_FLAG)
        cgapVal_next = regWrData[TIMER_W-1:0];
      else if (regAddr == OFS_STATUS_A)
      begin
        reason_next = reason_reg & ~regWrData[31:26];
        if (regWrData[POS_CLOSED])
          closed_next = 1'b0;
      end
    end

    if (regRdStb)
    begin
      if (regAddr == OFS_CTRL)
        rdData_next = {27'h000_0000, ctrl_reg};
      else if (regAddr == OFS_STATUS_A)
        rdData_next = statusWord;
      else if (regAddr == OFS_FIFO)
      begin
        rdData_next = hold_reg;
        holdValid_next = 1'b0;
        // no word left to describe, so the count returns to its reset code
        holdCnt_next = RST_COUNT;
      end
      else if (regAddr == OFS_MATCH)
        rdData_next = match_reg;
      else if (regAddr == OFS_BUFFER_TIMEOUT_FLAG)
        rdData_next = 32'(bgapVal_reg);
      else if (regAddr == OFS_CHAR_TIMEOUT_FLAG)
        rdData_next = 32'(cgapVal_reg);
    end

    if (bufOpen_reg)
    begin
      bufTmr_next = bufTmr_reg + 1'b1;
      chrTmr_next = chrTmr_reg + 1'b1;
    end

    if (byteTake)
    begin
      asm_next[{lane, 3'b000} +: 8] = rxByte;
      asmCnt_next = asmCnt_reg + 3'h1;
      chrTmr_next = '0;
      if (!bufOpen_reg)
      begin
        bufOpen_next = 1'b1;
        bufTmr_next  = '0;
      end
    end

    if (closeNow)
    begin
      reason_next  = newReason;
      bufOpen_next = 1'b0;
      flushPend_next = 1'b1;
      // dma moves the reasons to the descriptor and needs no acknowledge
      if (ctrl_reg.dmaMode)
      begin
        desc_next.valid  = 1'b1;
        desc_next.status = statusWord[31:16];
        desc_next.status[15:10] = newReason;
      end
      else
        closed_next = 1'b1;
    end

    // hand the assembled word on when full or when its buffer closed
    if (!holdValid_reg && asmCnt_reg != RST_COUNT
        && (asmCnt_reg == WORD_BYTES || flushPend_reg))
    begin
      hold_next      = asm_reg;
      holdCnt_next   = asmCnt_reg;
      holdValid_next = 1'b1;
      asm_next       = RST_WORD;
      asmCnt_next    = byteTake ? 3'h1 : RST_COUNT;
      if (byteTake)
        asm_next[{ctrl_reg.littleOrder ? 2'd0 : 2'd3, 3'b000} +: 8] = rxByte;
      flushPend_next = closeNow;
    end
    else if (flushPend_reg && asmCnt_reg == RST_COUNT && !closeNow)
      flushPend_next = 1'b0;
  end

  // stored levels move only once the two late stages agree
  always_comb
  begin
    modem_next = modem_reg;
    for (int i = 0; i < 4; i++)
      if (sync2_reg[i] == sync3_reg[i])
        modem_next[i] = sync3_reg[i];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg      <= srb_ctrl_t'(RST_CTRL);
      match_reg     <= RST_WORD;
      bgapVal_reg   <= '0;
      cgapVal_reg   <= '0;
      bufTmr_reg    <= '0;
      chrTmr_reg    <= '0;
      bufOpen_reg   <= 1'b0;
      reason_reg    <= 6'h00;
      closed_reg    <= 1'b0;
      asm_reg       <= RST_WORD;
      asmCnt_reg    <= RST_COUNT;
      hold_reg      <= RST_WORD;
      holdCnt_reg   <= RST_COUNT;
      holdValid_reg <= 1'b0;
      flushPend_reg <= 1'b0;
      rdData_reg    <= RST_WORD;
      desc_reg      <= '0;
      sync1_reg     <= 4'h0;
      sync2_reg     <= 4'h0;
      sync3_reg     <= 4'h0;
      modem_reg     <= 4'h0;
    end
    else
    begin
      ctrl_reg      <= ctrl_next;
      match_reg     <= match_next;
      bgapVal_reg   <= bgapVal_next;
      cgapVal_reg   <= cgapVal_next;
      bufTmr_reg    <= bufTmr_next;
      chrTmr_reg    <= chrTmr_next;
      bufOpen_reg   <= bufOpen_next;
      reason_reg    <= reason_next;
      closed_reg    <= closed_next;
      asm_reg       <= asm_next;
      asmCnt_reg    <= asmCnt_next;
      hold_reg      <= hold_next;
      holdCnt_reg   <= holdCnt_next;
      holdValid_reg <= holdValid_next;
      flushPend_reg <= flushPend_next;
      rdData_reg    <= rdData_next;
      desc_reg      <= desc_next;
      sync1_reg     <= {carrierDetectPin, ringPin, dataSetReadyPin, clearToSendPin};
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      modem_reg     <= modem_next;
    end
  end

  assign regRdData = rdData_reg;
  assign descOut   = desc_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_pend_closed: assert property (closed_reg |-> !statusWord[POS_PENDING])
    else $error("word pending shown while buffer closed");
  chk_match_flags: assert property (matchClose |=> reason_reg[5:2] == $past(hitVec))
    else $error("match close did not record hit flags");
  chk_buffer_timeout_flag_flag: assert property (bgapExp |=> reason_reg[1] && !bufOpen_reg)
    else $error("buffer timeout did not set flag and close");
  chk_char_timeout_flag_flag: assert property (cgapExp |=> reason_reg[0] && !bufOpen_reg)
    else $error("char timeout did not set flag and close");
  chk_dma_desc: assert property (closeNow && ctrl_reg.dmaMode |=>
      descOut.valid && descOut.status[15:10] == $past(newReason) && !closed_reg)
    else $error("descriptor status missing at dma close");
  chk_count_code: assert property (holdValid_reg && holdCnt_reg == WORD_BYTES
      |-> statusWord[21:20] == 2'b00)
    else $error("full word not coded as 00");
  chk_modem_follow: assert property ($stable(carrierDetectPin)[*5]
      |-> modem_reg[3] == carrierDetectPin)
    else $error("carrier detect state lags its input");
  chk_w1c_clear: assert property (regWrStb && regAddr == OFS_STATUS_A
      && regWrData[31] && !closeNow |=> !reason_reg[5])
    else $error("write one did not clear hit flag");
  chk_rsvd_zero: assert property (regRdStb && regAddr == OFS_STATUS_A
      |=> regRdData[25:22] == 4'h0 && regRdData[31:26] == $past(reason_reg))
    else $error("status read returned wrong upper bits");

  cov_match_close: cover property (matchClose ##1 closed_reg);
  cov_buffer_timeout_flag_close: cover property (bgapExp);
  cov_char_timeout_flag_close: cover property (cgapExp);
  cov_dma_desc: cover property (descOut.valid);
endmodule : srb_status
`default_nettype wire

// [verification/srb_remote_model.sv]
// remote serial end: delivers one received byte per request, drives modem levels
// assumes requests arrive from the bench just after ref_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module srb_remote_model
  import srb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sendStb,
  input  wire logic [7:0] sendData,
  input  wire logic [3:0] modemLvl,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            carrierDetectPin,
  output logic            ringPin,
  output logic            dataSetReadyPin,
  output logic            clearToSendPin
);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxValid <= 1'b0;
      rxByte  <= 8'h00;
    end
    else
    begin
      rxValid <= sendStb;
      // idle data toggles so a stale byte is never mistaken for a fresh one
      rxByte  <= sendStb ? sendData : ~rxByte;
    end
  end
  // levels change freely, unrelated to ref_clk phase
  assign {carrierDetectPin, ringPin, dataSetReadyPin, clearToSendPin} = modemLvl;
endmodule : srb_remote_model
`default_nettype wire

// [verification/serial_rx_buffer_close_status_tb.sv]
// bench for the receive buffer close status block: register tasks and directed checks
// assumes srb_status with small timer values and the remote model on the stream side
`timescale 1ns/1ps
`default_nettype none
module serial_rx_buffer_close_status_tb
  import srb_pkg::*;
;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic              ref_clk;
  logic              rst;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData;
  logic              regWrStb;
  logic              regRdStb;
  logic [31:0]       regRdData;
  logic              rxValid;
  logic [7:0]        rxByte;
  logic              cdPin, riPin, dsrPin, ctsPin;
  srb_desc_t         descOut;
  logic              sendStb;
  logic [7:0]        sendData;
  logic [3:0]        modemLvl;
  int                failures;
  int                comparisons;
  logic [31:0]       d;
  logic [15:0]       st;
  srb_status #(.TIMER_W(8)) dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .rxValid(rxValid), .rxByte(rxByte),
    .carrierDetectPin(cdPin), .ringPin(riPin), .dataSetReadyPin(dsrPin),
    .clearToSendPin(ctsPin), .descOut(descOut));
  srb_remote_model far_u (.ref_clk(ref_clk), .rst(rst), .sendStb(sendStb),
    .sendData(sendData), .modemLvl(modemLvl), .rxValid(rxValid), .rxByte(rxByte),
    .carrierDetectPin(cdPin), .ringPin(riPin), .dataSetReadyPin(dsrPin),
    .clearToSendPin(ctsPin));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
  begin
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
  begin
    @(posedge ref_clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWrStb  <= 1'b0;
  end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
  begin
    @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    // data stands only in the cycle after the strobe
    @(negedge ref_clk);
    v = regRdData;
  end
  endtask : rd
  task automatic send(input logic [7:0] b);
  begin
    @(posedge ref_clk);
    sendStb  <= 1'b1;
    sendData <= b;
    @(posedge ref_clk);
    sendStb  <= 1'b0;
  end
  endtask : send
  task automatic dmaClose(input logic [31:0] c, input logic [7:0] b);
  begin
    wr(OFS_CTRL, c);
    send(b);
    st = 16'hFFFF;
    for (int i = 0; i < 20 && st === 16'hFFFF; i++)
    begin
      @(negedge ref_clk);
      if (descOut.valid === 1'b1)
        st = descOut.status;
    end
  end
  endtask : dmaClose
  task automatic waitClosed;
    int k;
  begin
    for (k = 0; k < 30; k++)
    begin
      rd(OFS_STATUS_A, d);
      if (d[POS_CLOSED] === 1'b1)
        break;
    end
    if (k == 30)
    begin
      failures++;
      finish_test();
    end
    else
      // the tail word reaches the holding stage one cycle after the close
      rd(OFS_STATUS_A, d);
  end
  endtask : waitClosed
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
  initial
  begin
    rst = 1'b1; regAddr = '0; regWrData = '0; regWrStb = 1'b0; regRdStb = 1'b0;
    sendStb = 1'b0; sendData = 8'h00; modemLvl = 4'h0; failures = 0; comparisons = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_STATUS_A, d);
    `CHK(d, RST_WORD)
    rd(8'h40, d);
    `CHK(d, 32'h0000_0000)
    // char gap close, three bytes, first byte in the top lane
    wr(OFS_CHAR_TIMEOUT_FLAG, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_0004);
    send(8'h11); send(8'h22); send(8'h33);
    waitClosed();
    `CHK(d, 32'h0430_0200)
    rd(OFS_FIFO, d);
    `CHK(d & 32'hFFFF_FF00, 32'h1122_3300)
    wr(OFS_STATUS_A, 32'h0400_0200);
    rd(OFS_STATUS_A, d);
    `CHK(d, 32'h0000_0000)
    // match on the fourth character, little byte order
    wr(OFS_MATCH, 32'h7E00_0000);
    wr(OFS_CTRL, 32'h0000_0011);
    send(8'h41); send(8'h7E);
    waitClosed();
    `CHK(d, 32'h1020_0200)
    wr(OFS_STATUS_A, 32'h0000_0200);
    rd(OFS_STATUS_A, d);
    `CHK(d, 32'h1020_0800)
    rd(OFS_FIFO, d);
    `CHK(d & 32'h0000_FFFF, 32'h0000_7E41)
    wr(OFS_STATUS_A, 32'h9000_0000);
    // buffer gap close after a single byte
    wr(OFS_BUFFER_TIMEOUT_FLAG, 32'h0000_0006);
    wr(OFS_CTRL, 32'h0000_0002);
    send(8'h5A);
    waitClosed();
    `CHK(d, 32'h0810_0200)
    rd(OFS_FIFO, d);
    `CHK(d & 32'hFF00_0000, 32'h5A00_0000)
    wr(OFS_STATUS_A, 32'h0800_0200);
    // modem levels, through the synchroniser
    modemLvl <= 4'hA;
    repeat (8) @(posedge ref_clk);
    rd(OFS_STATUS_A, d);
    `CHK(d[19:16], 4'hA)
    modemLvl <= 4'h5;
    repeat (8) @(posedge ref_clk);
    rd(OFS_STATUS_A, d);
    `CHK(d, 32'h0005_0000)
    // dma close on the first character: reasons go to the descriptor
    wr(OFS_MATCH, 32'h0000_0055);
    dmaClose(32'h0000_0009, 8'h55);
    `CHK(st[15:10], 6'b10_0000)
    `CHK(st[3:0], 4'h5)
    // char gap close in dma mode
    dmaClose(32'h0000_000C, 8'h12);
    `CHK(st[15:10], 6'b00_0001)
    rd(OFS_FIFO, d);
    `CHK(d, 32'h5500_0000)
    // buffer gap close in dma mode
    dmaClose(32'h0000_000A, 8'h34);
    `CHK(st[15:10], 6'b00_0010)
    finish_test();
  end
endmodule : serial_rx_buffer_close_status_tb
`default_nettype wire
